// ==== src/stepper_ctrl_end.sv ====
// motion controller end: register port and pulse generation
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "stepper_link_cfg.svh"
module stepper_ctrl_end #(
   parameter int HOME_HALF_CYC = `SPL_HOME_HALF_CYC
) (
   input  wire logic        clk_in,         // 100 MHz clock
   input  wire logic        rst_n_in,       // sync reset, low
   input  wire logic [3:0]  addr_in,        // register byte address
   input  wire logic [31:0] wdata_in,       // write data
   input  wire logic        wr_in,          // write strobe
   input  wire logic        rd_in,          // read strobe
   output logic      [31:0] rdata_out,      // read data, next cycle
   stepper_link.controller  link            // isolated lines
);

   localparam logic [23:0] MIN_HALF = 24'(`SPL_MIN_HALF_CYC);
   localparam logic [23:0] HOME_HALF = 24'(HOME_HALF_CYC);

   stepper_link_pkg::ctrl_state_t state_reg, state_next;
   logic [15:0] count_reg;
   logic [23:0] half_reg, timer_reg, eff_half;
   logic        dir_reg, dual_reg, awo_reg, sel_req_reg, home_reg;
   logic        sel_pin_reg, stop_reg;
   logic        a_reg, b_reg;
   logic [31:0] rdata_reg, rd_mux;
   logic [1:0]  s1_reg, s2_reg, s3_reg, filt_reg;
   logic        wr_ctrl, wr_count, wr_half, start, timer_done, busy;
   logic        sel_apply, last_step;

   // feedback lines from the driver; one means conducting
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s1_reg   <= 2'h0;
         s2_reg   <= 2'h0;
         s3_reg   <= 2'h0;
         filt_reg <= 2'h0;
      end else begin
         s1_reg   <= {link.phase_home, link.fault};
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg))
                   | (filt_reg & (s2_reg ^ s3_reg));
      end
   end

   assign wr_ctrl  = wr_in && (addr_in == `SPL_OFS_CTRL);
   assign wr_count = wr_in && (addr_in == `SPL_OFS_COUNT);
   assign wr_half  = wr_in && (addr_in == `SPL_OFS_HALF);
   assign busy     = (state_reg != stepper_link_pkg::CTRL_IDLE);
   assign start    = wr_ctrl && wdata_in[`SPL_CTRL_START] && !busy
                     && (count_reg != 16'h0000);
   // the home output is only trustworthy at low rates
   assign eff_half = home_reg ? ((half_reg > HOME_HALF) ? half_reg
                                                        : HOME_HALF)
                              : ((half_reg > MIN_HALF) ? half_reg
                                                       : MIN_HALF);
   assign timer_done = (timer_reg >= eff_half - 24'h000001);
   assign last_step  = (count_reg == 16'h0001) || stop_reg;
   // angle changes wait for standstill at excitation step 0
   assign sel_apply  = !busy && filt_reg[1]
                       && (sel_req_reg != sel_pin_reg);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         stepper_link_pkg::CTRL_IDLE:
            if (start) state_next = stepper_link_pkg::CTRL_LOW;
         stepper_link_pkg::CTRL_LOW:
            if (timer_done) state_next = stop_reg
                               ? stepper_link_pkg::CTRL_IDLE
                               : stepper_link_pkg::CTRL_HIGH;
         stepper_link_pkg::CTRL_HIGH:
            if (timer_done) state_next = last_step
                               ? stepper_link_pkg::CTRL_IDLE
                               : stepper_link_pkg::CTRL_LOW;
         default:
            state_next = stepper_link_pkg::CTRL_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg <= stepper_link_pkg::CTRL_IDLE;
         timer_reg <= 24'h000000;
      end else begin
         state_reg <= state_next;
         timer_reg <= (state_next != state_reg) ? 24'h000000
                                                : timer_reg + 24'h000001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count_reg   <= 16'h0000;
         half_reg    <= `SPL_RST_HALF;
         dir_reg     <= 1'b0;
         dual_reg    <= 1'b0;
         awo_reg     <= 1'b0;
         sel_req_reg <= 1'b0;
         home_reg    <= 1'b0;
         stop_reg    <= 1'b0;
         sel_pin_reg <= 1'b0;
      end else begin
         if (wr_count && !busy) count_reg <= wdata_in[15:0];
         else if (state_reg == stepper_link_pkg::CTRL_HIGH && timer_done)
            count_reg <= stop_reg ? 16'h0000 : count_reg - 16'h0001;
         if (wr_half) half_reg <= wdata_in[23:0];
         if (wr_ctrl && !busy) begin
            dir_reg  <= wdata_in[`SPL_CTRL_DIR];
            dual_reg <= wdata_in[`SPL_CTRL_DUAL];
            home_reg <= wdata_in[`SPL_CTRL_HOME];
         end
         if (wr_ctrl) begin
            awo_reg     <= wdata_in[`SPL_CTRL_AWO];
            sel_req_reg <= wdata_in[`SPL_CTRL_SEL];
         end
         if (wr_ctrl && wdata_in[`SPL_CTRL_STOP] && busy) stop_reg <= 1'b1;
         else if (!busy) stop_reg <= 1'b0;
         if (sel_apply) sel_pin_reg <= sel_req_reg;
      end
   end

   // pulse lines rest off at standstill; direction leads by half a period
   // and trails the last pulse by a cycle, so it never moves beside an edge
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
      end else begin
         a_reg <= (state_next == stepper_link_pkg::CTRL_HIGH)
                  && (!dual_reg || dir_reg);
         b_reg <= dual_reg
                  ? ((state_next == stepper_link_pkg::CTRL_HIGH) && !dir_reg)
                  : (((state_next != stepper_link_pkg::CTRL_IDLE) || a_reg)
                     && dir_reg);
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (addr_in)
         `SPL_OFS_CTRL:   rd_mux = {25'h0000000, 1'b0, home_reg,
                                    sel_req_reg, awo_reg, dual_reg,
                                    dir_reg, 1'b0};
         `SPL_OFS_COUNT:  rd_mux = {16'h0000, count_reg};
         `SPL_OFS_HALF:   rd_mux = {8'h00, half_reg};
         `SPL_OFS_STATUS: rd_mux = {27'h0000000, sel_pin_reg,
                                    sel_req_reg != sel_pin_reg,
                                    filt_reg[1], ~filt_reg[0], busy};
         default:         rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) rdata_reg <= 32'h00000000;
      else           rdata_reg <= rd_in ? rd_mux : 32'h00000000;
   end

   assign rdata_out         = rdata_reg;
   assign link.line_a       = a_reg;
   assign link.line_b       = b_reg;
   assign link.windings_off = awo_reg;
   assign link.step_select  = sel_pin_reg;

endmodule : stepper_ctrl_end

// ==== src/stepper_link_cfg.svh ====
// constants shared by the stepper pulse link ends
`ifndef STEPPER_LINK_CFG_SVH
`define STEPPER_LINK_CFG_SVH

`define SPL_CLK_MHZ          100
// controller register byte offsets
`define SPL_OFS_CTRL         4'h0
`define SPL_OFS_COUNT        4'h4
`define SPL_OFS_HALF         4'h8
`define SPL_OFS_STATUS       4'hc
// control register fields
`define SPL_CTRL_START       0
`define SPL_CTRL_DIR         1
`define SPL_CTRL_DUAL        2
`define SPL_CTRL_AWO         3
`define SPL_CTRL_SEL         4
`define SPL_CTRL_HOME        5
`define SPL_CTRL_STOP        6
// status register fields
`define SPL_STAT_BUSY        0
`define SPL_STAT_FAULT       1
`define SPL_STAT_HOME        2
`define SPL_STAT_SEL_PEND    3
`define SPL_STAT_SEL_PIN     4
// reset values
`define SPL_RST_HALF         24'h000032
// timing: 1 MHz at 50 % duty gives a 500 ns half period
`define SPL_MIN_HALF_NS      500
`define SPL_MIN_HALF_CYC     ((`SPL_MIN_HALF_NS * `SPL_CLK_MHZ + 999) / 1000)
// timing: 500 Hz gives a 1000 us half period
`define SPL_HOME_HALF_US     1000
`define SPL_HOME_HALF_CYC    (`SPL_HOME_HALF_US * `SPL_CLK_MHZ)
// fault lamp blink half period
`define SPL_BLINK_MS         250
`define SPL_BLINK_CYC        (`SPL_BLINK_MS * 1000 * `SPL_CLK_MHZ)
// base-step counts per excitation cycle (7.2 deg)
`define SPL_BASE_LEN_5PH     12'h00a
`define SPL_BASE_LEN_2PH     12'h004

`endif

// ==== src/stepper_link_pkg.sv ====
// types shared by the stepper pulse link ends
package stepper_link_pkg;

   typedef enum logic [2:0] {
      CTRL_IDLE = 3'b001,
      CTRL_LOW  = 3'b010,
      CTRL_HIGH = 3'b100
   } ctrl_state_t;

   typedef logic [11:0] excite_len_t;

   // microsteps per excitation cycle for each resolution switch position
   function automatic excite_len_t excite_cycle_len(
      input logic       five_phase,
      input logic [3:0] pos
   );
      excite_len_t len;
      len = 12'h00a;
      if (five_phase) begin
         case (pos)
            4'h0: len = 12'h00a;  4'h1: len = 12'h014;
            4'h2: len = 12'h019;  4'h3: len = 12'h028;
            4'h4: len = 12'h032;  4'h5: len = 12'h050;
            4'h6: len = 12'h064;  4'h7: len = 12'h0c8;
            4'h8: len = 12'h0fa;  4'h9: len = 12'h190;
            4'ha: len = 12'h1f4;  4'hb: len = 12'h320;
            4'hc: len = 12'h3e8;  4'hd: len = 12'h4e2;
            4'he: len = 12'h7d0;  default: len = 12'h9c4;
         endcase
      end else begin
         case (pos)
            4'h0: len = 12'h004;  4'h1: len = 12'h008;
            4'h2: len = 12'h010;  4'h3: len = 12'h014;
            4'h4: len = 12'h020;  4'h5: len = 12'h028;
            4'h6: len = 12'h040;  4'h7: len = 12'h064;
            4'h8: len = 12'h080;  4'h9: len = 12'h0c8;
            4'ha: len = 12'h100;  4'hb: len = 12'h190;
            4'hc: len = 12'h1f4;  4'hd: len = 12'h200;
            4'he: len = 12'h3e8;  default: len = 12'h400;
         endcase
      end
      return len;
   endfunction : excite_cycle_len

endpackage : stepper_link_pkg

// ==== src/stepper_link.sv ====
// isolated signal lines between motion controller and motor driver
`timescale 1ns/1ps
interface stepper_link;
   logic line_a;        // step pulse, or forward pulse in dual mode
   logic line_b;        // direction, or reverse pulse in dual mode
   logic windings_off;  // 1 = conducting = winding current removed
   logic step_select;   // 1 = basic step angle
   logic fault;         // 1 = conducting = no alarm
   logic phase_home;    // 1 = excitation at step 0

   modport controller (
      output line_a, line_b, windings_off, step_select,
      input  fault, phase_home
   );
   modport driver (
      input  line_a, line_b, windings_off, step_select,
      output fault, phase_home
   );
endinterface : stepper_link

// ==== src/stepper_drive_end.sv ====
// motor driver end: pulse input decoding, excitation counter, alarm
`timescale 1ns/1ps
`include "stepper_link_cfg.svh"
module stepper_drive_end #(
   parameter int BLINK_CYCLES = `SPL_BLINK_CYC,
   parameter int CNT_W        = 12
) (
   input  wire logic             clk_in,            // 100 MHz clock
   input  wire logic             rst_n_in,          // sync reset, low
   stepper_link.driver           link,              // isolated lines
   input  wire logic             dual_mode_in,      // mode switch, pin
   input  wire logic             motor_family_in,   // 1 = five-phase, pin
   input  wire logic [3:0]       resolution_in,     // step switch, pin
   input  wire logic             alarm_in,          // internal fault sense
   output logic                  winding_en_out,    // winding current on
   output logic                  step_strobe_out,   // one microstep taken
   output logic                  step_dir_out,      // 1 = forward step
   output logic [CNT_W-1:0]      excite_step_out,   // excitation position
   output logic                  led_green_out,     // power lamp green
   output logic                  led_red_out        // power lamp red
);

   localparam int NUM_IN = 10;
   localparam int I_A    = 0;
   localparam int I_B    = 1;
   localparam int I_AWO  = 2;
   localparam int I_SEL  = 3;
   localparam int I_DUAL = 4;
   localparam int I_FAM  = 5;
   localparam int I_RES  = 6;

   logic [NUM_IN-1:0] raw_in;
   logic [NUM_IN-1:0] s1_reg, s2_reg, s3_reg;
   logic [NUM_IN-1:0] filt_reg, filt_next, prev_reg;
   logic [NUM_IN-1:0] rise;
   logic              alarm_reg;
   logic              fault_pin_reg;
   logic              home_reg;
   logic              wind_reg;
   logic              strobe_reg, dir_reg;
   logic [CNT_W-1:0]  cnt_reg, cnt_next;
   logic [31:0]       blink_cnt_reg;
   logic              blink_reg;
   logic [11:0]       sw_len;
   logic [CNT_W-1:0]  cyc_len;
   logic              dual, inhibit;
   logic              a_rise, b_level, b_rise;
   logic              step_fwd, step_rev, step_any;
   logic              cnt_top, cnt_out;

   // pins and switches all arrive from outside the clock domain
   assign raw_in = {resolution_in, motor_family_in, dual_mode_in,
                    link.step_select, link.windings_off,
                    link.line_b, link.line_a};

   // a level is taken once stages two and three agree
   assign filt_next = (s2_reg & ~(s2_reg ^ s3_reg))
                    | (filt_reg & (s2_reg ^ s3_reg));
   assign rise = filt_reg & ~prev_reg;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         filt_reg <= '0;
         prev_reg <= '0;
      end else begin
         s1_reg   <= raw_in;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
         prev_reg <= filt_reg;
      end
   end

   // pulse decoding
   assign dual     = filt_reg[I_DUAL];
   assign a_rise   = rise[I_A];
   assign b_rise   = rise[I_B];
   assign b_level  = filt_reg[I_B];
   // simultaneous edges in dual mode are meaningless, so both drop
   assign step_fwd = dual ? (a_rise & ~b_rise)
                          : (a_rise & b_level);
   assign step_rev = dual ? (b_rise & ~a_rise)
                          : (a_rise & ~b_level);
   assign inhibit  = filt_reg[I_AWO] | alarm_reg;
   assign step_any = (step_fwd | step_rev) & ~inhibit;

   // cycle length: basic angle, or microstep from the switches
   assign sw_len  = stepper_link_pkg::excite_cycle_len(
                       filt_reg[I_FAM], filt_reg[I_RES +: 4]);
   assign cyc_len = filt_reg[I_SEL]
                  ? (filt_reg[I_FAM] ? CNT_W'(`SPL_BASE_LEN_5PH)
                                     : CNT_W'(`SPL_BASE_LEN_2PH))
                  : CNT_W'(sw_len);

   // a switch change mid-cycle can leave the count above the new length
   assign cnt_out = (cnt_reg >= cyc_len);
   assign cnt_top = (cnt_reg >= cyc_len - CNT_W'(1));

   always_comb begin
      cnt_next = cnt_reg;
      if (step_any && step_fwd) begin
         cnt_next = (cnt_top || cnt_out) ? '0 : cnt_reg + CNT_W'(1);
      end else if (step_any) begin
         if (cnt_reg == '0 || cnt_out) begin
            cnt_next = cyc_len - CNT_W'(1);
         end else begin
            cnt_next = cnt_reg - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_reg    <= '0;
         strobe_reg <= 1'b0;
         dir_reg    <= 1'b0;
         home_reg   <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         strobe_reg <= step_any;
         if (step_any) begin
            dir_reg <= step_fwd;
         end
         home_reg   <= (cnt_next == '0);
      end
   end

   // alarm holds until reset; only rst_n_in low clears it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         alarm_reg     <= 1'b0;
         fault_pin_reg <= 1'b0;
         wind_reg      <= 1'b0;
      end else begin
         alarm_reg     <= alarm_reg | alarm_in;
         fault_pin_reg <= ~(alarm_reg | alarm_in);
         wind_reg      <= ~(filt_next[I_AWO] | alarm_reg
                            | alarm_in);
      end
   end

   // red lamp blinks during alarm
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (!alarm_reg) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b1;
      end else if (blink_cnt_reg >= 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_reg <= '0;
         blink_reg     <= ~blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
      end
   end

   assign link.fault      = fault_pin_reg;
   assign link.phase_home = home_reg;
   assign winding_en_out  = wind_reg;
   assign step_strobe_out = strobe_reg;
   assign step_dir_out    = dir_reg;
   assign excite_step_out = cnt_reg;
   assign led_green_out   = fault_pin_reg;
   assign led_red_out     = alarm_reg & blink_reg;

endmodule : stepper_drive_end

// ==== sim/stepper_link_properties.sv ====
// checker for the isolated lines between the two link ends
`timescale 1ns/1ps
module stepper_link_properties (
   input  wire logic clk_in,        // 100 MHz clock
   input  wire logic rst_n_in,      // sync reset, low
   input  wire logic line_a,        // step or forward pulse
   input  wire logic line_b,        // direction or reverse pulse
   input  wire logic windings_off,  // 1 = winding current cut
   input  wire logic step_select,   // 1 = basic step angle
   input  wire logic fault,         // 1 = no alarm
   input  wire logic phase_home     // 1 = excitation at step 0
);
   logic [7:0] hi_reg;
   logic [7:0] lo_reg;
   logic [7:0] awo_reg;
   logic [3:0] quiet_reg;

   // saturating run lengths, so long idle stretches never wrap
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         hi_reg    <= 8'h00;
         lo_reg    <= 8'hff;
         awo_reg   <= 8'h00;
         quiet_reg <= 4'h0;
      end else begin
         hi_reg    <= !line_a ? 8'h00 : hi_reg + {7'h00, hi_reg != 8'hff};
         lo_reg    <= line_a ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hff};
         awo_reg   <= !windings_off ? 8'h00
                      : awo_reg + {7'h00, awo_reg != 8'hff};
         quiet_reg <= ($changed(line_a) || $changed(line_b)) ? 4'h0
                      : quiet_reg + {3'h0, quiet_reg != 4'hf};
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   home_has_cause_a: assert property (
      $changed(phase_home) |-> quiet_reg <= 4'h8)
      else $error("home line moved with no pulse edge before it");
   fault_latch_a: assert property (
      $fell(fault) |=> !fault [*8])
      else $error("alarm output returned without a reset");
   pulse_high_a: assert property (
      $fell(line_a) |-> hi_reg >= 8'h32)
      else $error("pulse high time below minimum");
   pulse_low_a: assert property (
      $rose(line_a) |-> lo_reg >= 8'h32)
      else $error("pulse low time below minimum");
   sel_at_home_a: assert property (
      $changed(step_select) |-> phase_home && !line_a)
      else $error("step select changed away from home or in motion");
   awo_hold_a: assert property (
      awo_reg >= 8'h08 |-> $stable(phase_home))
      else $error("excitation moved with windings off");
   alarm_hold_a: assert property (
      !fault && !$past(fault) && $past(rst_n_in) |-> $stable(phase_home))
      else $error("excitation moved during alarm");
   dir_setup_a: assert property (
      $changed(line_b) |-> !line_a && !$past(line_a))
      else $error("direction changed around a pulse");

   cover property ($rose(phase_home));
   cover property ($rose(step_select));
   cover property ($fell(fault));
   cover property (windings_off && $rose(line_a));
endmodule : stepper_link_properties

// ==== sim/stepper_pulse_input_control_tb.sv ====
// self-checking bench joining controller end and driver end
`timescale 1ns/1ps
`include "stepper_link_cfg.svh"
`define CHECK(what, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module stepper_pulse_input_control_tb;
   logic        clk_in;
   logic        rst_n_in;
   logic [3:0]  addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   logic        dual_mode_in;
   logic        motor_family_in;
   logic [3:0]  resolution_in;
   logic        alarm_in;
   logic        winding_en_out;
   logic        step_strobe_out;
   logic        step_dir_out;
   logic [11:0] excite_step_out;
   logic        led_green_out;
   logic        led_red_out;
   logic [31:0] rd_val;
   int          failures;
   int          checks;
   int          strobes;
   int          cycles;

   stepper_link stepper_link_inst ();
   stepper_ctrl_end #(.HOME_HALF_CYC(200)) stepper_ctrl_end_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .link(stepper_link_inst));
   stepper_drive_end #(.BLINK_CYCLES(8)) stepper_drive_end_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .link(stepper_link_inst),
      .dual_mode_in(dual_mode_in), .motor_family_in(motor_family_in),
      .resolution_in(resolution_in), .alarm_in(alarm_in),
      .winding_en_out(winding_en_out), .step_strobe_out(step_strobe_out),
      .step_dir_out(step_dir_out), .excite_step_out(excite_step_out),
      .led_green_out(led_green_out), .led_red_out(led_red_out));
   stepper_link_properties stepper_link_properties_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in),
      .line_a(stepper_link_inst.line_a), .line_b(stepper_link_inst.line_b),
      .windings_off(stepper_link_inst.windings_off),
      .step_select(stepper_link_inst.step_select),
      .fault(stepper_link_inst.fault),
      .phase_home(stepper_link_inst.phase_home));

   always #5 clk_in = ~clk_in;

   // whole run needs roughly 13000 cycles
   always @(posedge clk_in) begin
      cycles++;
      if (step_strobe_out === 1'b1) strobes++;
      if (cycles == 40000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 rd_val = rdata_out;
   endtask : reg_rd

   // control word carries every mode bit, so callers pass the full value
   task automatic run(input logic [15:0] n, input logic [7:0] ctrl);
      int k;
      strobes = 0;
      reg_wr(`SPL_OFS_COUNT, {16'h0000, n});
      reg_wr(`SPL_OFS_CTRL, {24'h000000, ctrl});
      k = 0;
      rd_val = 32'h1;
      while (rd_val[`SPL_STAT_BUSY] === 1'b1 && k < 3000) begin
         reg_rd(`SPL_OFS_STATUS);
         k++;
      end
      `CHECK("run ended", 1'b0, rd_val[`SPL_STAT_BUSY])
      repeat (12) @(posedge clk_in);
      `CHECK("pulse idle", 1'b0, stepper_link_inst.line_a)
   endtask : run

   task automatic expect_pos(input int pos, input int n, input logic home);
      `CHECK("excite step", pos[11:0], excite_step_out)
      `CHECK("step count", n, strobes)
      `CHECK("home line", home, stepper_link_inst.phase_home)
   endtask : expect_pos

   task automatic t_reset;
      reg_rd(`SPL_OFS_HALF);
      `CHECK("half period", 32'h00000032, rd_val)
      reg_rd(4'h2);
      `CHECK("unmapped read", 32'h00000000, rd_val)
      reg_rd(`SPL_OFS_STATUS);
      `CHECK("status", 32'h00000004, rd_val)
      `CHECK("green lamp", 1'b1, led_green_out)
      `CHECK("red lamp", 1'b0, led_red_out)
      `CHECK("winding on", 1'b1, winding_en_out)
      $display("test reset done");
   endtask : t_reset

   task automatic t_single;
      run(16'h0003, 8'h03);
      expect_pos(3, 3, 1'b0);
      `CHECK("direction", 1'b1, step_dir_out)
      run(16'h0005, 8'h01);
      expect_pos(8, 5, 1'b0);
      `CHECK("direction", 1'b0, step_dir_out)
      // stop during the first low half: the run ends with no pulse at all
      strobes = 0;
      reg_wr(`SPL_OFS_COUNT, 32'h00000005);
      reg_wr(`SPL_OFS_CTRL, 32'h00000003);
      reg_wr(`SPL_OFS_CTRL, 32'h00000043);
      repeat (80) @(posedge clk_in);
      `CHECK("stop line", 1'b0, stepper_link_inst.line_a)
      expect_pos(8, 0, 1'b0);
      $display("test single pulse done");
   endtask : t_single

   task automatic t_dual;
      dual_mode_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      run(16'h0002, 8'h07);
      expect_pos(0, 2, 1'b1);
      run(16'h0001, 8'h05);
      expect_pos(9, 1, 1'b0);
      run(16'h0001, 8'h07);
      expect_pos(0, 1, 1'b1);
      dual_mode_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      $display("test dual pulse done");
   endtask : t_dual

   task automatic t_home;
      int c0;
      run(16'h0009, 8'h03);
      expect_pos(9, 9, 1'b0);
      run(16'h0001, 8'h03);
      expect_pos(0, 1, 1'b1);
      reg_rd(`SPL_OFS_STATUS);
      `CHECK("status home", 1'b1, rd_val[`SPL_STAT_HOME])
      // home mode: one whole excitation cycle at the slow rate
      c0 = cycles;
      run(16'h000a, 8'h23);
      expect_pos(0, 10, 1'b1);
      `CHECK("home rate", 1'b1, (cycles - c0) >= 4000)
      $display("test home done");
   endtask : t_home

   task automatic t_awo;
      reg_wr(`SPL_OFS_CTRL, 32'h00000008);
      repeat (10) @(posedge clk_in);
      `CHECK("winding off", 1'b0, winding_en_out)
      run(16'h0002, 8'h0b);
      expect_pos(0, 0, 1'b1);
      reg_wr(`SPL_OFS_CTRL, 32'h00000000);
      repeat (10) @(posedge clk_in);
      `CHECK("winding back", 1'b1, winding_en_out)
      $display("test windings off done");
   endtask : t_awo

   // switch position 4 gives 50 steps per cycle, basic angle gives 10
   task automatic t_select;
      resolution_in <= 4'h4;
      reg_wr(`SPL_OFS_CTRL, 32'h00000010);
      repeat (10) @(posedge clk_in);
      reg_rd(`SPL_OFS_STATUS);
      `CHECK("select line", 1'b1, rd_val[`SPL_STAT_SEL_PIN])
      run(16'h000a, 8'h13);
      expect_pos(0, 10, 1'b1);
      reg_wr(`SPL_OFS_CTRL, 32'h00000000);
      repeat (10) @(posedge clk_in);
      run(16'h000a, 8'h03);
      expect_pos(10, 10, 1'b0);
      run(16'h0028, 8'h03);
      expect_pos(0, 40, 1'b1);
      $display("test step select done");
   endtask : t_select

   task automatic t_alarm;
      int   tog;
      logic prev;
      alarm_in <= 1'b1;
      @(posedge clk_in);
      alarm_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      reg_rd(`SPL_OFS_STATUS);
      `CHECK("status alarm", 1'b1, rd_val[`SPL_STAT_FAULT])
      `CHECK("winding cut", 1'b0, winding_en_out)
      `CHECK("green off", 1'b0, led_green_out)
      tog = 0;
      prev = led_red_out;
      repeat (40) begin
         @(posedge clk_in);
         #1;
         if (led_red_out !== prev) tog++;
         prev = led_red_out;
      end
      `CHECK("red blink", 1'b1, tog >= 3)
      run(16'h0001, 8'h03);
      expect_pos(0, 0, 1'b1);
      rst_n_in <= 1'b0;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CHECK("fault clear", 1'b1, stepper_link_inst.fault)
      `CHECK("green again", 1'b1, led_green_out)
      $display("test alarm done");
   endtask : t_alarm

   initial begin
      clk_in = 1'b0;
      rst_n_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 32'h00000000;
      wr_in = 1'b0;
      rd_in = 1'b0;
      dual_mode_in = 1'b0;
      motor_family_in = 1'b1;
      resolution_in = 4'h0;
      alarm_in = 1'b0;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      t_reset();
      t_single();
      t_dual();
      t_home();
      t_awo();
      t_select();
      t_alarm();
      report_and_stop();
   end
endmodule : stepper_pulse_input_control_tb
